// ===== fpr_regstate.sv
// fp register stack, tag word, status/mode words and packed overlay
//
// Contract
// - eight data registers addressed from stack top
// - 16-bit tag word, reg7 high, reg0 low
// - tag codes valid zero special empty
// - denormal, inf, nan, unsupported tag special
// - tags kept automatically, seen only via env/save
// - status bit 15 mirrors error summary bit
// - top in 13:11, condition codes 14,10:8
// - unmasked exception sets error summary
// - overflow, underflow, bad access set stack fault
// - six exception flags in bits 5:0
// - six mask bits 5:0 gate trap report
// - rounding field bits 11:10 selects mode
// - precision field bits 9:8 selects width
// - eight packed registers share fp storage
// - state save/restore also covers packed regs
// - packed operand as bytes, words, dwords, quad
// - lanes independent, no carry across lanes
// - saturation clamps to type limits in byte and word lanes; dword and qword lanes always wrap
// - packed ops change no flags
// - empty-packed op zeros top, empties tags
`timescale 1ns/1ps
module fpr_regstate (
  // clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  ce,
  // command from the execution core
  input  wire fpr_pkg::fpr_cmd_type  cmd,
  // architectural words
  output logic [15:0]                status_word,
  output logic [15:0]                mode_control_word,
  // read answers
  output logic [79:0]                rd_data,
  output logic                       rd_valid,
  output fpr_pkg::fpr_env_type       env_out,
  // trap request to the core
  output logic                       trap_req
);

  // state
  logic [79:0]          phys_reg [fpr_pkg::NUM_REGS];
  logic [79:0]          phys_next [fpr_pkg::NUM_REGS];
  logic [15:0]          sw_reg;
  logic [15:0]          sw_next;
  logic [15:0]          mc_reg;
  logic [15:0]          mc_next;
  logic [15:0]          tag_reg;
  logic [15:0]          tag_next;
  logic [79:0]          rd_data_reg;
  logic [79:0]          rd_data_next;
  logic                 rd_valid_reg;
  logic                 rd_valid_next;
  fpr_pkg::fpr_env_type env_reg;
  fpr_pkg::fpr_env_type env_next;
  logic                 trap_reg;
  logic                 trap_next;
  logic [63:0]          alu_y;

  // class of an extended value: exponent 78:64, explicit integer bit 63
  function automatic logic [1:0] classify(input logic [79:0] v);
    if (v[78:64] == 15'h0000) begin
      classify = (v[63:0] == 64'h0) ? fpr_pkg::TAG_ZERO
                                    : fpr_pkg::TAG_SPECIAL;
    end else if (v[78:64] == 15'h7fff || !v[63]) begin
      classify = fpr_pkg::TAG_SPECIAL;
    end else begin
      classify = fpr_pkg::TAG_VALID;
    end
  endfunction

  // tag field of one physical register
  function automatic logic [1:0] tag_of(input logic [15:0] t,
                                        input logic [2:0]  r);
    tag_of = t[2*r +: 2];
  endfunction

  // tag word with one field replaced
  function automatic logic [15:0] tag_set(input logic [15:0] t,
                                          input logic [2:0]  r,
                                          input logic [1:0]  c);
    tag_set = t;
    tag_set[2*r +: 2] = c;
  endfunction

  // packed unit works on the low 64 bits of the shared storage
  fpr_packed_alu u_alu (
    .a     (phys_reg[cmd.idx][63:0]),
    .b     (phys_reg[cmd.src][63:0]),
    .esize (cmd.esize),
    .sub   (cmd.sub),
    .sat   (cmd.sat),
    .sgn   (cmd.sgn),
    .y     (alu_y)
  );

  // next state of the whole register file, one command per enabled cycle
  always_comb begin
    logic [2:0] top;
    logic [2:0] pos;
    logic [5:0] exc;
    logic [5:0] new_exc;
    logic [3:0] cc;
    logic       sf;
    logic       es;
    top      = sw_reg[fpr_pkg::SW_TOP_HI:fpr_pkg::SW_TOP_LO];
    pos      = 3'(top + cmd.idx);
    exc      = sw_reg[fpr_pkg::EXC_HI:0];
    new_exc  = 6'h00;
    cc       = {sw_reg[fpr_pkg::SW_CC3_BIT],
                sw_reg[fpr_pkg::SW_CC2_BIT:fpr_pkg::SW_CC0_BIT]};
    sf       = sw_reg[fpr_pkg::SW_SF_BIT];
    es       = sw_reg[fpr_pkg::SW_ES_BIT];
    phys_next     = phys_reg;
    mc_next       = mc_reg;
    tag_next      = tag_reg;
    rd_data_next  = rd_data_reg;
    rd_valid_next = 1'b0;
    env_next      = env_reg;
    env_next.valid = 1'b0;
    if (cmd.valid) begin
      case (cmd.op)
        fpr_pkg::OP_PUSH: begin
          top = 3'(top - 3'h1);
          if (tag_of(tag_reg, top) != fpr_pkg::TAG_EMPTY) begin
            // overflow keeps the old contents and tag, but still steps top down and reports
            sf = 1'b1;
            cc[1] = 1'b1;
            new_exc[fpr_pkg::EXC_INV_BIT] = 1'b1;
          end else begin
            phys_next[top] = cmd.data;
            tag_next = tag_set(tag_reg, top, classify(cmd.data));
          end
        end
        fpr_pkg::OP_POP: begin
          if (tag_of(tag_reg, top) == fpr_pkg::TAG_EMPTY) begin
            sf = 1'b1;
            cc[1] = 1'b0;
            new_exc[fpr_pkg::EXC_INV_BIT] = 1'b1;
          end
          tag_next = tag_set(tag_reg, top, fpr_pkg::TAG_EMPTY);
          top = 3'(top + 3'h1);
        end
        fpr_pkg::OP_WRITE_ST: begin
          phys_next[pos] = cmd.data;
          tag_next = tag_set(tag_reg, pos, classify(cmd.data));
        end
        fpr_pkg::OP_READ_ST: begin
          if (tag_of(tag_reg, pos) == fpr_pkg::TAG_EMPTY) begin
            sf = 1'b1;
            cc[1] = 1'b0;
            new_exc[fpr_pkg::EXC_INV_BIT] = 1'b1;
          end
          rd_data_next  = phys_reg[pos];
          rd_valid_next = 1'b1;
        end
        fpr_pkg::OP_RAISE: begin
          new_exc = cmd.flags;
          cc      = cmd.cc;
        end
        fpr_pkg::OP_CLEAR_EX: begin
          exc = 6'h00;
          sf  = 1'b0;
          es  = 1'b0;
        end
        fpr_pkg::OP_LOAD_MC: begin
          mc_next = cmd.data[15:0];
        end
        fpr_pkg::OP_STORE_ENV: begin
          env_next = '{1'b1, tag_reg, sw_reg, mc_reg};
        end
        fpr_pkg::OP_SAVE_REG: begin
          // save walks physical registers, so packed data comes along
          env_next      = '{1'b1, tag_reg, sw_reg, mc_reg};
          rd_data_next  = phys_reg[cmd.idx];
          rd_valid_next = 1'b1;
        end
        fpr_pkg::OP_RESTORE_ENV: begin
          mc_next  = cmd.data[15:0];
          tag_next = cmd.data[47:32];
          top = cmd.data[16+fpr_pkg::SW_TOP_HI:16+fpr_pkg::SW_TOP_LO];
          cc  = {cmd.data[16+fpr_pkg::SW_CC3_BIT],
                 cmd.data[16+fpr_pkg::SW_CC2_BIT:16+fpr_pkg::SW_CC0_BIT]};
          es  = cmd.data[16+fpr_pkg::SW_ES_BIT];
          sf  = cmd.data[16+fpr_pkg::SW_SF_BIT];
          exc = cmd.data[16+fpr_pkg::EXC_HI:16];
        end
        fpr_pkg::OP_RESTORE_REG: begin
          phys_next[cmd.idx] = cmd.data;
        end
        fpr_pkg::OP_PK_WRITE: begin
          phys_next[cmd.idx] = {fpr_pkg::PACKED_UPPER, cmd.data[63:0]};
          tag_next = tag_set(tag_reg, cmd.idx, fpr_pkg::TAG_VALID);
        end
        fpr_pkg::OP_PK_READ: begin
          rd_data_next  = {16'h0000, phys_reg[cmd.idx][63:0]};
          rd_valid_next = 1'b1;
        end
        fpr_pkg::OP_PK_ARITH: begin
          // lane overflow is clamped or wrapped, never flagged
          phys_next[cmd.idx] = {fpr_pkg::PACKED_UPPER, alu_y};
          tag_next = tag_set(tag_reg, cmd.idx, fpr_pkg::TAG_VALID);
          rd_data_next  = {16'h0000, alu_y};
          rd_valid_next = 1'b1;
        end
        fpr_pkg::OP_EMPTY_PK: begin
          top      = 3'h0;
          tag_next = fpr_pkg::TAG_RESET;
        end
        default: begin
        end
      endcase
    end
    // sticky flags; an unmasked new one raises the error summary
    exc = exc | new_exc;
    if ((new_exc & ~mc_reg[fpr_pkg::EXC_HI:0]) != 6'h00) begin
      es = 1'b1;
    end
    sw_next = {es, cc[3], top, cc[2:0], es, sf, exc};
    trap_next = es;
  end

  // registers only; the enable freezes everything
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < fpr_pkg::NUM_REGS; i++) begin
        phys_reg[i] <= 80'h0;
      end
      sw_reg       <= fpr_pkg::SW_RESET;
      mc_reg       <= fpr_pkg::MC_RESET;
      tag_reg      <= fpr_pkg::TAG_RESET;
      rd_data_reg  <= 80'h0;
      rd_valid_reg <= 1'b0;
      env_reg      <= '0;
      trap_reg     <= 1'b0;
    end else if (ce) begin
      phys_reg     <= phys_next;
      sw_reg       <= sw_next;
      mc_reg       <= mc_next;
      tag_reg      <= tag_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      env_reg      <= env_next;
      trap_reg     <= trap_next;
    end
  end

  // outputs straight from flops
  assign status_word       = sw_reg;
  assign mode_control_word = mc_reg;
  assign rd_data           = rd_data_reg;
  assign rd_valid          = rd_valid_reg;
  assign env_out           = env_reg;
  assign trap_req          = trap_reg;

  // checks
  es_mirror_a:
    assert property (@(posedge clk) disable iff (!arst_n)
      sw_reg[15] == sw_reg[7])
    else $error("bit 15 differs from error summary");

  push_top_a:
    assert property (@(posedge clk) disable iff (!arst_n)
      ce && cmd.valid && cmd.op == fpr_pkg::OP_PUSH
      |=> sw_reg[13:11] == 3'($past(sw_reg[13:11]) - 3'h1))
    else $error("push did not step the top down");

  push_zero_a:
    assert property (@(posedge clk) disable iff (!arst_n)
      ce && cmd.valid && cmd.op == fpr_pkg::OP_PUSH
      && tag_of(tag_reg, 3'(sw_reg[13:11] - 3'h1)) == 2'h3
      && cmd.data[78:0] == 79'h0
      |=> tag_of(tag_reg, sw_reg[13:11]) == 2'h1)
    else $error("zero push not tagged zero");

  overflow_sf_a:
    assert property (@(posedge clk) disable iff (!arst_n)
      ce && cmd.valid && cmd.op == fpr_pkg::OP_PUSH
      && tag_of(tag_reg, 3'(sw_reg[13:11] - 3'h1)) != 2'h3
      |=> sw_reg[6] && sw_reg[0])
    else $error("stack overflow not reported");

  unmasked_es_a:
    assert property (@(posedge clk) disable iff (!arst_n)
      ce && cmd.valid && cmd.op == fpr_pkg::OP_RAISE
      && (cmd.flags & ~mc_reg[5:0]) != 6'h00
      |=> sw_reg[7] && trap_req)
    else $error("unmasked exception missed error summary");

  empty_pk_a:
    assert property (@(posedge clk) disable iff (!arst_n)
      ce && cmd.valid && cmd.op == fpr_pkg::OP_EMPTY_PK
      |=> sw_reg[13:11] == 3'h0 && tag_reg == 16'hffff)
    else $error("empty-packed op left state");

  pk_tag_a:
    assert property (@(posedge clk) disable iff (!arst_n)
      ce && cmd.valid && (cmd.op == fpr_pkg::OP_PK_WRITE
      || cmd.op == fpr_pkg::OP_PK_ARITH)
      |=> tag_of(tag_reg, $past(cmd.idx)) != 2'h3)
    else $error("packed write left tag empty");

  pk_noflag_a:
    assert property (@(posedge clk) disable iff (!arst_n)
      ce && cmd.valid && cmd.op == fpr_pkg::OP_PK_ARITH
      |=> $stable(sw_reg))
    else $error("packed op changed status");

endmodule // fpr_regstate

// ===== fpr_pkg.sv
// shared constants, types and field layout of the fp/packed register state
package fpr_pkg;

  // storage geometry
  localparam int NUM_REGS   = 8;
  localparam int DATA_W     = 80;
  localparam int PACKED_W   = 64;
  localparam int WORD_W     = 16;

  // tag word codes, two bits per physical register
  localparam logic [1:0] TAG_VALID   = 2'h0;
  localparam logic [1:0] TAG_ZERO    = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY   = 2'h3;

  // status word field positions
  localparam int SW_BUSY_BIT = 15;
  localparam int SW_CC3_BIT  = 14;
  localparam int SW_TOP_HI   = 13;
  localparam int SW_TOP_LO   = 11;
  localparam int SW_CC2_BIT  = 10;
  localparam int SW_CC0_BIT  = 8;
  localparam int SW_ES_BIT   = 7;
  localparam int SW_SF_BIT   = 6;
  localparam int EXC_HI      = 5;
  localparam int EXC_INV_BIT = 0;

  // mode control word field positions
  localparam int MC_RC_HI = 11;
  localparam int MC_RC_LO = 10;
  localparam int MC_PC_HI = 9;
  localparam int MC_PC_LO = 8;

  // values after reset: all masked, nearest, 64-bit, everything empty
  localparam logic [15:0] SW_RESET  = 16'h0000;
  localparam logic [15:0] MC_RESET  = 16'h033f;
  localparam logic [15:0] TAG_RESET = 16'hffff;

  // upper bits written above a packed value in the shared storage
  localparam logic [15:0] PACKED_UPPER = 16'hffff;

  // rounding and precision encodings
  typedef enum logic [1:0] {
    RC_NEAREST = 2'b00,
    RC_DOWN    = 2'b01,
    RC_UP      = 2'b10,
    RC_TRUNC   = 2'b11
  } fpr_round_type;

  typedef enum logic [1:0] {
    PC_24   = 2'b00,
    PC_RSVD = 2'b01,
    PC_53   = 2'b10,
    PC_64   = 2'b11
  } fpr_prec_type;

  // packed element sizes
  typedef enum logic [1:0] {
    ES_BYTE  = 2'b00,
    ES_WORD  = 2'b01,
    ES_DWORD = 2'b10,
    ES_QWORD = 2'b11
  } fpr_esize_type;

  // operations issued by the execution core
  typedef enum logic [3:0] {
    OP_NOP         = 4'b0000,
    OP_PUSH        = 4'b0001,
    OP_POP         = 4'b0010,
    OP_WRITE_ST    = 4'b0011,
    OP_READ_ST     = 4'b0100,
    OP_RAISE       = 4'b0101,
    OP_CLEAR_EX    = 4'b0110,
    OP_LOAD_MC     = 4'b0111,
    OP_STORE_ENV   = 4'b1000,
    OP_SAVE_REG    = 4'b1001,
    OP_RESTORE_ENV = 4'b1010,
    OP_RESTORE_REG = 4'b1011,
    OP_PK_WRITE    = 4'b1100,
    OP_PK_READ     = 4'b1101,
    OP_PK_ARITH    = 4'b1110,
    OP_EMPTY_PK    = 4'b1111
  } fpr_op_type;

  // one command from the core
  typedef struct packed {
    logic          valid;
    fpr_op_type    op;
    logic [2:0]    idx;
    logic [2:0]    src;
    fpr_esize_type esize;
    logic          sub;
    logic          sat;
    logic          sgn;
    logic [3:0]    cc;
    logic [5:0]    flags;
    logic [79:0]   data;
  } fpr_cmd_type;

  // environment image handed back to the core
  typedef struct packed {
    logic        valid;
    logic [15:0] tags;
    logic [15:0] status;
    logic [15:0] control;
  } fpr_env_type;

endpackage

// ===== fpr_packed_alu.sv
// lane-wise packed add/subtract with optional saturation in byte and word lanes
`timescale 1ns/1ps
module fpr_packed_alu (
  // operands
  input  wire logic [63:0]            a,
  input  wire logic [63:0]            b,
  // operation select
  input  wire fpr_pkg::fpr_esize_type esize,
  input  wire logic                   sub,
  input  wire logic                   sat,
  input  wire logic                   sgn,
  // result
  output logic [63:0]                 y
);

  logic [63:0] small_res [2];
  logic [63:0] dword_res;
  logic [63:0] qword_res;

  // byte and word lanes, each with two guard bits so the clamp sees range
  for (genvar gs = 0; gs < 2; gs++) begin : g_size
    localparam int W = 8 << gs;
    for (genvar gl = 0; gl < (64 / W); gl++) begin : g_lane
      logic [W+1:0] ea;
      logic [W+1:0] eb;
      logic [W+1:0] s;
      assign ea = sgn ? {{2{a[gl*W+W-1]}}, a[gl*W +: W]}
                      : {2'b00, a[gl*W +: W]};
      assign eb = sgn ? {{2{b[gl*W+W-1]}}, b[gl*W +: W]}
                      : {2'b00, b[gl*W +: W]};
      assign s  = sub ? ea - eb : ea + eb;
      always_comb begin
        if (!sat) begin
          small_res[gs][gl*W +: W] = s[W-1:0];
        end else if (sgn) begin
          // signed limits 80h/7fh and 8000h/7fffh
          if (s[W+1:W-1] == 3'b000 || s[W+1:W-1] == 3'b111) begin
            small_res[gs][gl*W +: W] = s[W-1:0];
          end else begin
            small_res[gs][gl*W +: W] = s[W+1] ? {1'b1, {(W-1){1'b0}}}
                                              : {1'b0, {(W-1){1'b1}}};
          end
        end else if (s[W+1]) begin
          small_res[gs][gl*W +: W] = {W{1'b0}};
        end else if (s[W]) begin
          small_res[gs][gl*W +: W] = {W{1'b1}};
        end else begin
          small_res[gs][gl*W +: W] = s[W-1:0];
        end
      end
    end
  end

  // doubleword lanes wrap, no carry between halves
  for (genvar gd = 0; gd < 2; gd++) begin : g_dword
    assign dword_res[gd*32 +: 32] = sub ? a[gd*32 +: 32] - b[gd*32 +: 32]
                                        : a[gd*32 +: 32] + b[gd*32 +: 32];
  end
  assign qword_res = sub ? a - b : a + b;

  // element size picks the lane set
  always_comb begin
    case (esize)
      fpr_pkg::ES_BYTE:  y = small_res[0];
      fpr_pkg::ES_WORD:  y = small_res[1];
      fpr_pkg::ES_DWORD: y = dword_res;
      default:           y = qword_res;
    endcase
  end

endmodule // fpr_packed_alu

// ===== fpr_core_model.sv
// execution core model that issues commands and captures the answers
`timescale 1ns/1ps
module fpr_core_model (
  // clock
  input  wire logic                 clk,
  // command to the register state
  output fpr_pkg::fpr_cmd_type      cmd,
  // answers from the register state
  input  wire logic                 rd_valid,
  input  wire logic [79:0]          rd_data,
  input  wire fpr_pkg::fpr_env_type env_out
);
  logic                 got_rd;
  logic [79:0]          rd_got;
  fpr_pkg::fpr_env_type env_got;

  // idle command from time zero, so nothing is taken during reset
  initial begin
    cmd = '0;
  end

  // one command per call: held over the taking edge, answer read after it
  task automatic send(input fpr_pkg::fpr_cmd_type c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
    // the answer pulses stand one cycle only, so take them now
    got_rd = rd_valid;
    rd_got = rd_data;
    env_got = env_out;
  endtask
endmodule // fpr_core_model

// ===== fpr_packed_register_state_test.sv
// self-checking bench for the fp and packed register state
`timescale 1ns/1ps
module fpr_packed_register_state_test;
  logic                 clk;
  logic                 arst_n;
  logic                 ce;
  fpr_pkg::fpr_cmd_type cmd;
  logic [15:0]          status_word;
  logic [15:0]          mode_control_word;
  logic [79:0]          rd_data;
  logic                 rd_valid;
  fpr_pkg::fpr_env_type env_out;
  logic                 trap_req;
  int                   fails;
  int                   check_count;
  int                   cycles = 0;
  logic [15:0]          st0;

  // operand classes pushed onto the stack
  localparam logic [79:0] V_NORM = {16'h3fff, 64'h8000_0000_0000_0000};
  localparam logic [79:0] V_INF  = {16'h7fff, 64'h8000_0000_0000_0000};
  localparam logic [79:0] V_DEN  = {16'h0000, 64'h0000_0000_0000_0001};

  fpr_regstate fpr_regstate_i (
    .clk               (clk),
    .arst_n            (arst_n),
    .ce                (ce),
    .cmd               (cmd),
    .status_word       (status_word),
    .mode_control_word (mode_control_word),
    .rd_data           (rd_data),
    .rd_valid          (rd_valid),
    .env_out           (env_out),
    .trap_req          (trap_req)
  );

  fpr_core_model fpr_core_model_i (
    .clk      (clk),
    .cmd      (cmd),
    .rd_valid (rd_valid),
    .rd_data  (rd_data),
    .env_out  (env_out)
  );

  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // the whole run is about 130 cycles; this only cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic fpr_pkg::fpr_cmd_type mk(fpr_pkg::fpr_op_type op,
                                              logic [2:0] idx,
                                              logic [79:0] d);
    fpr_pkg::fpr_cmd_type r;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.idx = idx;
    r.data = d;
    return r;
  endfunction

  task automatic go(input fpr_pkg::fpr_op_type op, input logic [2:0] idx,
                    input logic [79:0] d);
    fpr_core_model_i.send(mk(op, idx, d));
  endtask

  // raise condition codes and exception flags in one command
  task automatic raise(input logic [3:0] cc, input logic [5:0] fl);
    fpr_pkg::fpr_cmd_type c;
    c = mk(fpr_pkg::OP_RAISE, 3'h0, 80'h0);
    c.cc = cc;
    c.flags = fl;
    fpr_core_model_i.send(c);
  endtask

  // environment store: tags are visible only this way or through a register save
  task automatic env(input logic [15:0] t, input logic [15:0] s,
                     input logic [15:0] m);
    go(fpr_pkg::OP_STORE_ENV, 3'h0, 80'h0);
    chk(fpr_core_model_i.env_got.valid, 80'h1, "env valid");
    chk(fpr_core_model_i.got_rd, 80'h0, "env no read");
    chk(fpr_core_model_i.env_got.tags, t, "env tags");
    chk(fpr_core_model_i.env_got.status, s, "env status");
    chk(fpr_core_model_i.env_got.control, m, "env control");
  endtask

  // reg0 op reg1 into reg0; status must not move on packed work
  task automatic pcase(input fpr_pkg::fpr_esize_type es, input logic sub,
                       input logic sat, input logic sgn,
                       input logic [63:0] a, input logic [63:0] b,
                       input logic [63:0] exp);
    fpr_pkg::fpr_cmd_type c;
    go(fpr_pkg::OP_PK_WRITE, 3'h0, {16'h0, a});
    go(fpr_pkg::OP_PK_WRITE, 3'h1, {16'h0, b});
    st0 = status_word;
    c = mk(fpr_pkg::OP_PK_ARITH, 3'h0, 80'h0);
    c.src = 3'h1;
    c.esize = es;
    c.sub = sub;
    c.sat = sat;
    c.sgn = sgn;
    fpr_core_model_i.send(c);
    chk(fpr_core_model_i.rd_got, {16'h0, exp}, "packed result");
    chk(fpr_core_model_i.got_rd, 80'h1, "packed valid");
    chk(status_word, st0, "packed flags");
  endtask

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    chk(status_word, 16'h0000, "status reset");
    chk(mode_control_word, 16'h033f, "mode reset");
    env(16'hffff, 16'h0000, 16'h033f);
    // every rounding code with each defined precision code
    for (int r = 0; r < 4; r++) begin
      for (int p = 0; p < 4; p++) begin
        if (p != 1) begin
          go(fpr_pkg::OP_LOAD_MC, 3'h0,
             {64'h0, 4'h0, r[1:0], p[1:0], 2'b00, 6'h3f});
          chk(mode_control_word, {4'h0, r[1:0], p[1:0], 2'b00, 6'h3f},
              "mode");
        end
      end
    end
    go(fpr_pkg::OP_LOAD_MC, 3'h0, 80'h033f);
    // four pushes fill physical 7 down to 4 with each class
    go(fpr_pkg::OP_PUSH, 3'h0, 80'h0);
    go(fpr_pkg::OP_PUSH, 3'h0, V_NORM);
    go(fpr_pkg::OP_PUSH, 3'h0, V_INF);
    go(fpr_pkg::OP_PUSH, 3'h0, V_DEN);
    env(16'h4aff, 16'h2000, 16'h033f);
    go(fpr_pkg::OP_READ_ST, 3'h0, 80'h0);
    chk(fpr_core_model_i.rd_got, V_DEN, "read st0");
    chk(fpr_core_model_i.got_rd, 80'h1, "read valid");
    go(fpr_pkg::OP_READ_ST, 3'h2, 80'h0);
    chk(fpr_core_model_i.rd_got, V_NORM, "read st2");
    // reading an empty slot is a stack fault with invalid set
    go(fpr_pkg::OP_READ_ST, 3'h4, 80'h0);
    chk(status_word, 16'h2041, "stack fault");
    go(fpr_pkg::OP_CLEAR_EX, 3'h0, 80'h0);
    chk(status_word, 16'h2000, "clear");
    // masked exceptions set flags but no error summary
    raise(4'ha, 6'h3e);
    chk(status_word, 16'h623e, "masked raise");
    go(fpr_pkg::OP_CLEAR_EX, 3'h0, 80'h0);
    chk(status_word & 16'h80ff, 16'h0000, "clear");
    // unmask divide by zero only, then raise it
    go(fpr_pkg::OP_LOAD_MC, 3'h0, 80'h033b);
    raise(4'ha, 6'h04);
    chk(status_word, 16'he284, "unmasked raise");
    @(posedge clk);
    #1;
    chk(trap_req, 1'b1, "trap");
    go(fpr_pkg::OP_CLEAR_EX, 3'h0, 80'h0);
    go(fpr_pkg::OP_LOAD_MC, 3'h0, 80'h033f);
    go(fpr_pkg::OP_EMPTY_PK, 3'h0, 80'h0);
    env(16'hffff, 16'h4200, 16'h033f);
    // lane cases: wrap, saturation at each limit, dword against qword
    pcase(fpr_pkg::ES_BYTE, 0, 0, 0, 64'hffff_ffff_ffff_ffff,
          64'h0101_0101_0101_0101, 64'h0);
    pcase(fpr_pkg::ES_BYTE, 0, 1, 1, 64'h7f80_7f80_7f80_7f80,
          64'h01ff_0101_ff01_0000, 64'h7f80_7f81_7e81_7f80);
    pcase(fpr_pkg::ES_BYTE, 1, 1, 0, 64'h0010_0010_0010_0010,
          64'h0101_0101_0101_0101, 64'h000f_000f_000f_000f);
    pcase(fpr_pkg::ES_WORD, 0, 1, 0, 64'hffff_0001_8000_1234,
          64'h0001_0001_8000_0000, 64'hffff_0002_ffff_1234);
    pcase(fpr_pkg::ES_WORD, 1, 1, 1, 64'h8000_7fff_0000_1234,
          64'h0001_ffff_0001_0000, 64'h8000_7fff_ffff_1234);
    pcase(fpr_pkg::ES_QWORD, 0, 0, 0, 64'hffff_ffff_0000_0001,
          64'h0000_0001_ffff_ffff, 64'h0000_0001_0000_0000);
    pcase(fpr_pkg::ES_DWORD, 0, 1, 0, 64'hffff_ffff_0000_0001,
          64'h0000_0001_ffff_ffff, 64'h0);
    env(16'hfff0, 16'h4200, 16'h033f);
    // packed contents come out through the full state save
    go(fpr_pkg::OP_SAVE_REG, 3'h1, 80'h0);
    chk(fpr_core_model_i.rd_got, {16'hffff, 64'h0000_0001_ffff_ffff},
        "save packed");
    go(fpr_pkg::OP_RESTORE_ENV, 3'h0, {32'h0, 16'h0fff, 16'h1800,
       16'h0f3f});
    go(fpr_pkg::OP_RESTORE_REG, 3'h2, {16'hffff, 64'h1234_5678_9abc_def0});
    env(16'h0fff, 16'h1800, 16'h0f3f);
    go(fpr_pkg::OP_SAVE_REG, 3'h2, 80'h0);
    chk(fpr_core_model_i.rd_got, {16'hffff, 64'h1234_5678_9abc_def0},
        "restore reg");
    // with the clock enable low a push must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    go(fpr_pkg::OP_PUSH, 3'h0, V_NORM);
    chk(status_word, 16'h1800, "ce low");
    ce <= 1'b1;
    // popping an empty top is an underflow; a full stack refuses a push
    go(fpr_pkg::OP_POP, 3'h0, 80'h0);
    chk(status_word, 16'h2041, "underflow");
    go(fpr_pkg::OP_RESTORE_ENV, 3'h0, {32'h0, 16'h0000, 16'h1800,
       16'h0f3f});
    go(fpr_pkg::OP_PUSH, 3'h0, V_NORM);
    chk(status_word, 16'h1241, "overflow");
    go(fpr_pkg::OP_SAVE_REG, 3'h2, 80'h0);
    chk(fpr_core_model_i.rd_got, {16'hffff, 64'h1234_5678_9abc_def0},
        "overflow kept data");
    summarize();
  end
endmodule // fpr_packed_register_state_test
